// ==== ccp_unit_bank.sv ====
/*
 * Four capture/compare/PWM units behind an AXI4-Lite register slave, with
 * a sticky event status, an event mask and one level interrupt.
 * Assumes per-unit 16-bit timer counts and a 10-bit PWM time base on the
 * same clock, a one-cycle message-received pulse from the bus controller on
 * the same clock, and asynchronous capture pins.
 */
`default_nettype none
`timescale 1ns/1ps

// Overview of operation
// - Mode code 0000 disables a unit and clears its internal state, so it does nothing.
// - Mode 0010 toggles the unit pin on each compare match and sets the unit event flag.
// - Mode 0100 captures on each falling input edge, or on each received message if selected.
// - Mode 0101 captures on each rising input edge, or on each received message if selected.
// - Mode 0110 captures on every fourth rising edge or every fourth received message.
// - Mode 0111 captures on every sixteenth rising edge or every sixteenth received message.
// - Mode 1000 starts the pin low and forces it high on a match, setting the event flag.
// - Mode 1001 starts the pin high and forces it low on a match, setting the event flag.
// - Mode 1011 resets the unit timer on a match and sets the flag, with no conversion start.
// - Codes 11xx select PWM with a 10-bit duty made of two control bits and the value low byte.
// - Each unit has one 16-bit value register used for capture, compare or duty.
// - Only the first unit can take the message time stamp, which then replaces its pin.
// - All four units behave alike, except that only the first can take the message time stamp.
module ccp_unit_bank (
	input  wire logic                                clk_sys_in,
	input  wire logic                                srst_in,
	// AXI4-Lite slave
	input  wire logic [ccp_pkg::ADDR_W-1:0]          s_axi_awaddr_in,
	input  wire logic                                s_axi_awvalid_in,
	output var  logic                                s_axi_awready_out,
	input  wire logic [ccp_pkg::DATA_W-1:0]          s_axi_wdata_in,
	input  wire logic [3:0]                          s_axi_wstrb_in,
	input  wire logic                                s_axi_wvalid_in,
	output var  logic                                s_axi_wready_out,
	output var  logic [1:0]                          s_axi_bresp_out,
	output var  logic                                s_axi_bvalid_out,
	input  wire logic                                s_axi_bready_in,
	input  wire logic [ccp_pkg::ADDR_W-1:0]          s_axi_araddr_in,
	input  wire logic                                s_axi_arvalid_in,
	output var  logic                                s_axi_arready_out,
	output var  logic [ccp_pkg::DATA_W-1:0]          s_axi_rdata_out,
	output var  logic [1:0]                          s_axi_rresp_out,
	output var  logic                                s_axi_rvalid_out,
	input  wire logic                                s_axi_rready_in,
	// Unit surroundings
	input  wire ccp_pkg::ccp_timers_t                timers_in,
	input  wire logic [ccp_pkg::DUTY_W-1:0]          pwm_base_in,
	input  wire logic                                msg_received_in,
	input  wire logic [ccp_pkg::UNITS-1:0]           cap_pin_in,
	output var  logic [ccp_pkg::UNITS-1:0]           unit_pin_out,
	output var  logic [ccp_pkg::UNITS-1:0]           unit_pin_oe_out,
	output var  logic [ccp_pkg::UNITS-1:0]           timer_reset_out,
	output var  logic                                irq_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Address decode, shared by the write and read paths
	function automatic ccp_pkg::ccp_dec_t decode(input logic [ccp_pkg::ADDR_W-1:0] a);
		ccp_pkg::ccp_dec_t d;
		d         = '0;
		d.unit    = a[5:4];
		d.slot    = a[3:2];
		d.is_unit = (a < ccp_pkg::UNIT_AREA_END);
		if (d.is_unit) begin
			d.hit = (d.slot == ccp_pkg::SLOT_CONTROL) || (d.slot == ccp_pkg::SLOT_VALUE);
		end else begin
			d.hit = (a == ccp_pkg::ADDR_STATUS) || (a == ccp_pkg::ADDR_MASK) ||
			        (a == ccp_pkg::ADDR_BUS_IO) || (a == ccp_pkg::ADDR_PIN_STATE);
		end
		return d;
	endfunction : decode

	// Codes 11xx are PWM whatever the low two bits hold
	function automatic logic is_pwm(input logic [3:0] mode);
		return mode[3:2] == ccp_pkg::MODE_PWM_TOP;
	endfunction : is_pwm

	// Modes in which the unit owns the pin
	function automatic logic drives_pin(input logic [3:0] mode);
		return is_pwm(mode) || (mode == ccp_pkg::MODE_TOGGLE) ||
		       (mode == ccp_pkg::MODE_SET_HIGH) || (mode == ccp_pkg::MODE_SET_LOW);
	endfunction : drives_pin

	// ----------------------------------------------------------------
	// State and sub-blocks
	// ----------------------------------------------------------------
	ccp_pkg::ccp_state_t          s;
	ccp_pkg::ccp_state_t          next_s;
	logic [ccp_pkg::UNITS-1:0]    cap_level;
	logic [ccp_pkg::UNITS-1:0]    pwm_level;

	// Pins are asynchronous, so every capture input is synchronised first
	ccp_sync #(
		.WIDTH (ccp_pkg::UNITS)
	) u_sync (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.async_in   (cap_pin_in),
		.level_out  (cap_level)
	);

	// One PWM comparator per unit; duty is value low byte plus two control bits
	for (genvar g = 0; g < ccp_pkg::UNITS; g++) begin : g_pwm
		ccp_pwm u_pwm (
			.clk_sys_in (clk_sys_in),
			.srst_in    (srst_in),
			.enable_in  (is_pwm(s.unit[g].ctrl[ccp_pkg::MODE_LSB +: 4])),
			.base_in    (pwm_base_in),
			.duty_in    ({s.unit[g].value[7:0],
			              s.unit[g].ctrl[ccp_pkg::DUTY_LOW_LSB +: 2]}),
			.level_out  (pwm_level[g])
		);
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Bus handshakes, unit behaviour, then status and interrupt
	always_comb begin
		ccp_pkg::ccp_dec_t  wd;
		ccp_pkg::ccp_dec_t  rd;
		logic               wr_fire;
		logic               rd_fire;
		logic               clear_status;
		logic [3:0]         ev;
		logic [3:0]         mode;
		logic [3:0]         new_mode;
		logic [15:0]        tv;
		logic               rise;
		logic               fall;
		logic               src_rise;
		logic               src_fall;
		logic               match;
		logic               cap;
		wd           = decode(s_axi_awaddr_in);
		rd           = decode(s_axi_araddr_in);
		wr_fire      = s_axi_awvalid_in && s.awready && s_axi_wvalid_in && s.wready;
		rd_fire      = s_axi_arvalid_in && s.arready;
		clear_status = 1'b0;
		ev           = '0;
		mode         = '0;
		new_mode     = '0;
		tv           = '0;
		rise         = 1'b0;
		fall         = 1'b0;
		src_rise     = 1'b0;
		src_fall     = 1'b0;
		match        = 1'b0;
		cap          = 1'b0;
		next_s       = s;
		// Write channel: take address and data together, answer next cycle
		next_s.awready = s_axi_awvalid_in && s_axi_wvalid_in && !s.awready && !s.bvalid;
		next_s.wready  = next_s.awready;
		if (wr_fire) begin
			next_s.bvalid = 1'b1;
			next_s.bresp  = wd.hit ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
			if (!wd.is_unit && s_axi_wstrb_in[0]) begin
				if (s_axi_awaddr_in == ccp_pkg::ADDR_MASK) begin
					next_s.mask = s_axi_wdata_in[ccp_pkg::UNITS-1:0];
				end
				if (s_axi_awaddr_in == ccp_pkg::ADDR_BUS_IO) begin
					next_s.stamp_sel = s_axi_wdata_in[ccp_pkg::STAMP_SEL_BIT];
				end
			end
		end else if (s.bvalid && s_axi_bready_in) begin
			next_s.bvalid = 1'b0;
		end
		// Read channel: a status read clears the sticky bits it returns
		next_s.arready = s_axi_arvalid_in && !s.arready && !s.rvalid;
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = rd.hit ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
			next_s.rdata  = '0;
			if (rd.hit && rd.is_unit) begin
				if (rd.slot == ccp_pkg::SLOT_CONTROL) begin
					next_s.rdata[ccp_pkg::CTRL_W-1:0] = s.unit[rd.unit].ctrl; // Bits 7:6 read 0
				end else begin
					next_s.rdata[ccp_pkg::VALUE_W-1:0] = s.unit[rd.unit].value;
				end
			end else if (s_axi_araddr_in == ccp_pkg::ADDR_STATUS) begin
				next_s.rdata[ccp_pkg::UNITS-1:0] = s.status;
				clear_status                     = 1'b1;
			end else if (s_axi_araddr_in == ccp_pkg::ADDR_MASK) begin
				next_s.rdata[ccp_pkg::UNITS-1:0] = s.mask;
			end else if (s_axi_araddr_in == ccp_pkg::ADDR_BUS_IO) begin
				next_s.rdata[ccp_pkg::STAMP_SEL_BIT] = s.stamp_sel;
			end else if (s_axi_araddr_in == ccp_pkg::ADDR_PIN_STATE) begin
				next_s.rdata[ccp_pkg::UNITS-1:0] = s.pin;
			end
		end else if (s.rvalid && s_axi_rready_in) begin
			next_s.rvalid = 1'b0;
		end
		// Units: identical logic, only the index differs
		next_s.tmr_rst = '0;
		for (int i = 0; i < ccp_pkg::UNITS; i++) begin
			mode     = s.unit[i].ctrl[ccp_pkg::MODE_LSB +: 4];
			tv       = timers_in.count[i];
			rise     = cap_level[i] && !s.unit[i].prev_in;
			fall     = !cap_level[i] && s.unit[i].prev_in;
			// Message pulse replaces the pin on unit 0 only
			src_rise = (i == 0 && s.stamp_sel) ? msg_received_in : rise;
			src_fall = (i == 0 && s.stamp_sel) ? msg_received_in : fall;
			match    = (tv == s.unit[i].value);
			cap      = 1'b0;
			next_s.unit[i].prev_in    = cap_level[i];
			next_s.unit[i].prev_match = match;
			// Matches count once, when equality begins, so a stalled timer
			// does not flood the flag
			unique case (mode)
				ccp_pkg::MODE_CAP_FALL:   cap = src_fall;
				ccp_pkg::MODE_CAP_RISE:   cap = src_rise;
				ccp_pkg::MODE_CAP_RISE4,
				ccp_pkg::MODE_CAP_RISE16: begin
					if (src_rise) begin
						if (s.unit[i].presc == ((mode == ccp_pkg::MODE_CAP_RISE4) ?
						    ccp_pkg::PRESC4_LAST : ccp_pkg::PRESC16_LAST)) begin
							cap                   = 1'b1;
							next_s.unit[i].presc = ccp_pkg::PRESC_ZERO;
						end else begin
							next_s.unit[i].presc = s.unit[i].presc + 4'h1;
						end
					end
				end
				ccp_pkg::MODE_TOGGLE: begin
					if (match && !s.unit[i].prev_match) begin
						next_s.pin[i] = !s.pin[i];
						ev[i]         = 1'b1;
					end
				end
				ccp_pkg::MODE_SET_HIGH: begin
					if (match && !s.unit[i].prev_match) begin
						next_s.pin[i] = 1'b1;
						ev[i]         = 1'b1;
					end
				end
				ccp_pkg::MODE_SET_LOW: begin
					if (match && !s.unit[i].prev_match) begin
						next_s.pin[i] = 1'b0;
						ev[i]         = 1'b1;
					end
				end
				ccp_pkg::MODE_FLAG_ONLY: begin
					ev[i] = match && !s.unit[i].prev_match;
				end
				ccp_pkg::MODE_SPECIAL: begin
					// Timer reset only; no conversion start leaves this block
					if (match && !s.unit[i].prev_match) begin
						next_s.tmr_rst[i] = 1'b1;
						ev[i]             = 1'b1;
					end
				end
				default: begin
					// Off, reserved codes and PWM: no capture or compare here
					if (is_pwm(mode)) begin
						next_s.pin[i] = pwm_level[i];
					end
				end
			endcase
			// Capture copies the timer and flags in the same cycle
			if (cap) begin
				next_s.unit[i].value = tv;
				ev[i]                = 1'b1;
			end
			// Value register writes; a capture in the same cycle wins
			if (wr_fire && wd.is_unit && wd.unit == 2'(i) && wd.slot == ccp_pkg::SLOT_VALUE
			    && !cap) begin
				if (s_axi_wstrb_in[0]) begin
					next_s.unit[i].value[7:0] = s_axi_wdata_in[7:0];
				end
				if (s_axi_wstrb_in[1]) begin
					next_s.unit[i].value[15:8] = s_axi_wdata_in[15:8];
				end
			end
			// Control writes restart the unit in its new mode
			if (wr_fire && wd.is_unit && wd.unit == 2'(i) &&
			    wd.slot == ccp_pkg::SLOT_CONTROL && s_axi_wstrb_in[0]) begin
				new_mode                  = s_axi_wdata_in[ccp_pkg::MODE_LSB +: 4];
				next_s.unit[i].ctrl       = s_axi_wdata_in[ccp_pkg::CTRL_W-1:0];
				next_s.unit[i].presc      = ccp_pkg::PRESC_ZERO;
				next_s.unit[i].prev_match = 1'b1;                         // No match on entry
				if (new_mode == ccp_pkg::MODE_OFF) begin
					next_s.unit[i].presc = ccp_pkg::PRESC_ZERO;
					next_s.pin[i]        = 1'b0;
					next_s.tmr_rst[i]    = 1'b0;
					ev[i]                = 1'b0;
				end else if (new_mode == ccp_pkg::MODE_SET_HIGH) begin
					next_s.pin[i] = 1'b0;
				end else if (new_mode == ccp_pkg::MODE_SET_LOW) begin
					next_s.pin[i] = 1'b1;
				end
			end
			next_s.pin_oe[i] = drives_pin(next_s.unit[i].ctrl[ccp_pkg::MODE_LSB +: 4]);
		end

		// Sticky status: a new event wins over a clearing read
		next_s.status = (clear_status ? '0 : s.status) | ev;
		next_s.irq    = |(next_s.status & next_s.mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Synchronous reset leaves every unit in the disabled mode
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign s_axi_awready_out = s.awready;
	assign s_axi_wready_out  = s.wready;
	assign s_axi_bresp_out   = s.bresp;
	assign s_axi_bvalid_out  = s.bvalid;
	assign s_axi_arready_out = s.arready;
	assign s_axi_rdata_out   = s.rdata;
	assign s_axi_rresp_out   = s.rresp;
	assign s_axi_rvalid_out  = s.rvalid;
	assign unit_pin_out      = s.pin;
	assign unit_pin_oe_out   = s.pin_oe;
	assign timer_reset_out   = s.tmr_rst;
	assign irq_out           = s.irq;

endmodule : ccp_unit_bank

`default_nettype wire

// ==== ccp_pkg.sv ====
/*
 * Shared constants and types for the four-unit capture/compare/PWM block:
 * register offsets, field positions, mode codes, bus answers and carriers.
 * Assumes it is compiled before every other file of the block.
 */
`default_nettype none

package ccp_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int UNITS    = 4;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int VALUE_W  = 16;
	localparam int DUTY_W   = 10;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] UNIT_AREA_END  = 8'h40; // Per-unit pairs below this
	localparam logic [1:0] SLOT_CONTROL   = 2'h0;  // unit_control at base + 0x0
	localparam logic [1:0] SLOT_VALUE     = 2'h1;  // Value register at base + 0x4
	localparam logic [7:0] ADDR_STATUS    = 8'h40;
	localparam logic [7:0] ADDR_MASK      = 8'h44;
	localparam logic [7:0] ADDR_BUS_IO    = 8'h48;
	localparam logic [7:0] ADDR_PIN_STATE = 8'h4c;

	// unit_control fields
	localparam int CTRL_W        = 6;
	localparam int MODE_LSB      = 0;
	localparam int DUTY_LOW_LSB  = 4;
	// bus_io_control: message_stamp_select bit
	localparam int STAMP_SEL_BIT = 4;

	// ----------------------------------------------------------------
	// Mode codes of unit_mode_field
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_OFF        = 4'h0;
	localparam logic [3:0] MODE_TOGGLE     = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_SET_HIGH   = 4'h8;
	localparam logic [3:0] MODE_SET_LOW    = 4'h9;
	localparam logic [3:0] MODE_FLAG_ONLY  = 4'ha;
	localparam logic [3:0] MODE_SPECIAL    = 4'hb;
	localparam logic [1:0] MODE_PWM_TOP    = 2'h3; // Upper two bits 11 mean PWM

	// Prescaler terminal counts
	localparam logic [3:0] PRESC_ZERO   = 4'h0;
	localparam logic [3:0] PRESC4_LAST  = 4'h3;
	localparam logic [3:0] PRESC16_LAST = 4'hf;

	// AXI answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [CTRL_W-1:0]  ctrl;       // {duty_low_bits, unit_mode_field}
		logic [VALUE_W-1:0] value;      // Capture, compare or duty value
		logic               prev_in;    // Last synchronised input level
		logic               prev_match; // Last compare result
		logic [3:0]         presc;      // Capture prescale count
	} ccp_unit_t;

	typedef struct packed {
		logic       hit;
		logic       is_unit;
		logic [1:0] unit;
		logic [1:0] slot;
	} ccp_dec_t;

	typedef struct packed {
		logic               awready;
		logic               wready;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               arready;
		logic               rvalid;
		logic [1:0]         rresp;
		logic [DATA_W-1:0]  rdata;
		ccp_unit_t [UNITS-1:0] unit;
		logic [UNITS-1:0]   status;
		logic [UNITS-1:0]   mask;
		logic               stamp_sel;
		logic [UNITS-1:0]   pin;
		logic [UNITS-1:0]   pin_oe;
		logic [UNITS-1:0]   tmr_rst;
		logic               irq;
	} ccp_state_t;

	typedef struct packed {
		logic [UNITS-1:0][VALUE_W-1:0] count;
	} ccp_timers_t;

endpackage : ccp_pkg

`default_nettype wire

// ==== ccp_sync.sv ====
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous levels; only the second stage is read.
 */
`default_nettype none
`timescale 1ns/1ps

module ccp_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk_sys_in,
	input  wire logic             srst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] level_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} ccp_sync_state_t;

	ccp_sync_state_t s;
	ccp_sync_state_t next_s;

	// ----------------------------------------------------------------
	// Stages
	// ----------------------------------------------------------------
	// First stage feeds only the second stage
	always_comb begin
		next_s.meta   = async_in;
		next_s.stable = s.meta;
	end

	// Register the copy
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level_out = s.stable;

endmodule : ccp_sync

`default_nettype wire

// ==== ccp_pwm.sv ====
/*
 * Ten-bit PWM comparator for one unit.
 * Assumes a shared 10-bit time base on the same clock that wraps to zero;
 * the duty value is taken over only when the base is zero, so a period
 * never sees a half-written duty.
 */
`default_nettype none
`timescale 1ns/1ps

module ccp_pwm (
	input  wire logic                       clk_sys_in,
	input  wire logic                       srst_in,
	input  wire logic                       enable_in,
	input  wire logic [ccp_pkg::DUTY_W-1:0] base_in,
	input  wire logic [ccp_pkg::DUTY_W-1:0] duty_in,
	output var  logic                       level_out
);

	typedef struct packed {
		logic [ccp_pkg::DUTY_W-1:0] duty;
		logic                       level;
	} ccp_pwm_state_t;

	ccp_pwm_state_t s;
	ccp_pwm_state_t next_s;

	// ----------------------------------------------------------------
	// Duty latch and compare
	// ----------------------------------------------------------------
	// Disabled unit holds its output low and its latched duty cleared
	always_comb begin
		next_s = s;
		if (!enable_in) begin
			next_s = '0;
		end else begin
			if (base_in == '0) begin
				next_s.duty = duty_in;
			end
			next_s.level = (base_in < next_s.duty);
		end
	end

	// Register the copy
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level_out = s.level;

endmodule : ccp_pwm

`default_nettype wire

// ==== ccp_pin_model.sv ====
/* Far side of the unit bank: capture pins and message pulses.
 * Assumes the bench commands it on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_model (
	input  wire logic       clk_sys_in,
	input  wire logic [3:0] level_in,
	input  wire logic       send_in,
	output var  logic [3:0] cap_pin_out = '0,
	output var  logic       msg_out = '0
);
	// Pins follow one edge late; a message is one cycle, never a level
	always_ff @(posedge clk_sys_in) begin
		cap_pin_out <= level_in;
		msg_out     <= send_in && !msg_out;
	end
endmodule : ccp_pin_model
`default_nettype wire

// ==== ccp_unit_bank_asserts.sv ====
/* Port checker for ccp_unit_bank.
 * Assumes the bind at the foot and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ccp_unit_bank_asserts (
	input wire logic        clk_sys_in,
	input wire logic        srst_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [3:0]  unit_pin_oe_out,
	input wire logic [3:0]  timer_reset_out,
	input wire logic        irq_out
);
	// ----
	// Bus and unit relations
	// ----
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	a_wr_pair: assert property (s_axi_awready_out == s_axi_wready_out) else $error("ready split");
	a_wr_take: assert property ($rose(s_axi_awready_out) |-> $past(s_axi_awvalid_in
		&& s_axi_wvalid_in)) else $error("write taken early");
	a_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out |=> s_axi_bvalid_out)
		else $error("no write answer");
	a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
		&& $stable(s_axi_bresp_out)) else $error("write answer dropped");
	a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("no read answer");
	a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
		&& $stable(s_axi_rdata_out)) else $error("read answer dropped");
	a_trst_pulse: assert property (|timer_reset_out |=> timer_reset_out == '0)
		else $error("timer reset too long");
	a_trst_nopin: assert property ((timer_reset_out & unit_pin_oe_out) == '0)
		else $error("timer reset while driving");
	// Reset leaves the units idle; not disabled, as it watches reset itself
	a_reset_idle: assert property (disable iff (1'b0) srst_in |=> !irq_out
		&& unit_pin_oe_out == '0 && !s_axi_bvalid_out) else $error("busy after reset");
	cover property (|timer_reset_out);
	cover property ($rose(irq_out));
	cover property (s_axi_bvalid_out && s_axi_bresp_out == ccp_pkg::RESP_SLVERR);
endmodule : ccp_unit_bank_asserts
bind ccp_unit_bank ccp_unit_bank_asserts ccp_unit_bank_asserts_inst (.clk_sys_in, .srst_in,
	.s_axi_awvalid_in, .s_axi_wvalid_in, .s_axi_awready_out, .s_axi_wready_out,
	.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in,
	.unit_pin_oe_out, .timer_reset_out, .irq_out);
`default_nettype wire

// ==== ccp_unit_bank_bench.sv ====
/* Bench for ccp_unit_bank: AXI4-Lite tasks and unit scenarios.
 * Assumes ccp_pkg, the design, the pin model and the checker. */
`timescale 1ns/1ps
`default_nettype none
module ccp_unit_bank_bench;
	logic clk_sys_in, srst_in = 1'h1, s_axi_awvalid_in = '0, s_axi_wvalid_in = '0, send = '0;
	logic s_axi_bready_in = '0, s_axi_arvalid_in = '0, s_axi_rready_in = '0, old;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, irq_out, msg_received_in;
	logic [7:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
	logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hf, lvl = '0, cap_pin_in, unit_pin_out, unit_pin_oe_out;
	logic [3:0] timer_reset_out, md [5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [9:0] pwm_base_in = '0;
	ccp_pkg::ccp_timers_t timers_in = '0;
	int mismatches = 0, cmp_count = 0, trst = 0, hi;
	ccp_unit_bank ccp_unit_bank_inst (.clk_sys_in, .srst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
		.timers_in, .pwm_base_in, .msg_received_in, .cap_pin_in, .unit_pin_out, .unit_pin_oe_out,
		.timer_reset_out, .irq_out);
	ccp_pin_model ccp_pin_model_inst (.clk_sys_in, .level_in(lvl), .send_in(send),
		.cap_pin_out(cap_pin_in), .msg_out(msg_received_in));
	initial begin
		clk_sys_in = 1'h0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	// Free time base that wraps through zero; unit 1 timer resets counted
	always @(posedge clk_sys_in) begin
		pwm_base_in <= pwm_base_in + 10'h1;
		trst <= trst + int'(timer_reset_out[1]);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Each task starts a clock late so no strobe is set twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = '0);
		@(posedge clk_sys_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'h0;
		chk(s_axi_bresp_out, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = '0);
		@(posedge clk_sys_in);
		s_axi_araddr_in <= a;
		{s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
		end while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'h0;
		chk(s_axi_rdata_out, e);
		chk(s_axi_rresp_out, r);
	endtask : rd
	task automatic close_out();
		$display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (6) @(posedge clk_sys_in);
		srst_in <= 1'h0;
		rd(8'h00, '0);
		rd(8'h40, '0);
		rd(8'h50, '0, ccp_pkg::RESP_SLVERR);
		wr(8'h50, 32'h1, ccp_pkg::RESP_SLVERR);
		wr(8'h44, 32'hf);
		timers_in.count[1] <= 16'h1234;
		wr(8'h10, 32'h5);
		lvl[1] <= 1'h1;
		repeat (6) @(posedge clk_sys_in);
		chk(irq_out, 1'h1);
		rd(8'h14, 32'h1234);
		rd(8'h40, 32'h2);
		rd(8'h40, '0);
		chk(irq_out, 1'h0);
		wr(8'h44, 32'hb);
		wr(8'h20, 32'h4);
		lvl[2] <= 1'h1;
		repeat (6) @(posedge clk_sys_in);
		rd(8'h40, '0);
		lvl[2] <= 1'h0;
		repeat (6) @(posedge clk_sys_in);
		chk(irq_out, 1'h0);
		rd(8'h40, 32'h4);
		// Prescaled capture on unit 3: every fourth, then every sixteenth edge
		for (int n = 4; n <= 16; n += 12) begin
			wr(8'h30, (n == 4) ? 32'h6 : 32'h7);
			for (int e = 1; e <= n; e++) begin
				lvl[3] <= 1'h1;
				repeat (5) @(posedge clk_sys_in);
				lvl[3] <= 1'h0;
				repeat (5) @(posedge clk_sys_in);
				chk(irq_out, e == n);
			end
			rd(8'h40, 32'h8);
		end
		wr(8'h48, 32'h10);
		wr(8'h00, 32'h5);
		timers_in.count[0] <= 16'h0abc;
		send <= 1'h1;
		@(posedge clk_sys_in);
		send <= 1'h0;
		repeat (4) @(posedge clk_sys_in);
		rd(8'h04, 32'h0abc);
		rd(8'h40, 32'h1);
		// Compare modes on unit 1 against a reference of 0x0100
		timers_in.count[1] <= '0;
		wr(8'h14, 32'h100);
		foreach (md[k]) begin
			wr(8'h10, {28'h0, md[k]});
			repeat (2) @(posedge clk_sys_in);
			if (md[k] == 4'h8 || md[k] == 4'h9) chk(unit_pin_out[1], md[k][0]);
			old = unit_pin_out[1];
			timers_in.count[1] <= 16'h0100;
			repeat (4) @(posedge clk_sys_in);
			timers_in.count[1] <= '0;
			chk(unit_pin_oe_out[1], md[k] < 4'ha);
			if (md[k] < 4'ha) chk(unit_pin_out[1], md[k] == 4'h8 || (md[k] == 4'h2 && !old));
			rd(8'h40, 32'h2);
		end
		chk(trst, 1);
		wr(8'h24, 32'h40);
		wr(8'h20, 32'h2c);
		do @(posedge clk_sys_in); while (pwm_base_in != 10'h0);
		do @(posedge clk_sys_in); while (pwm_base_in != 10'h2);
		hi = 0;
		repeat (1024) begin
			@(posedge clk_sys_in);
			hi += unit_pin_out[2];
		end
		chk(hi, 32'h102);
		wr(8'h20, '0);
		repeat (2) @(posedge clk_sys_in);
		chk({unit_pin_oe_out[2], unit_pin_out[2]}, '0);
		close_out();
	end
	// Hang guard, well past the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		mismatches++;
		close_out();
	end
endmodule : ccp_unit_bank_bench
`default_nettype wire
